// [core/asis_seq.sv]
// The address map and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
// Functional notes
// [RULE1] with fill splitting on, fill the first buffer half, swap halves at each interrupt.
// [RULE2] with fill splitting off, every fill starts at the buffer start address.
// [RULE3] with alternation on, use set one on the first sample, then alternate each sample.
// [RULE4] with alternation off, every sample uses the first input set.
// [RULE5] select codes 0 to 15 connect analog pins 0 to 15 directly.
// [RULE6] code 31 leaves the channel-0 positive input open.
// [RULE7] code 30 connects the temperature diode of the charge-time unit.
// [RULE8] code 26 routes op-amp 3 or pin 6, code 24 routes op-amp 1 or pin 3.
// [RULE9] software must not program the reserved select codes.
// [RULE10] an op-amp code takes the amp output when its mode bit is set, else the pin.
// [RULE11] buffer half and input set return to their first positions on reset or disable.
module asis_seq (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire asis_pkg::asis_axil_req_t   axil_req,
    output var  asis_pkg::asis_axil_rsp_t   axil_rsp,
    input  wire logic                       sample_done,
    input  wire logic                       fill_irq,
    output var  asis_pkg::asis_route_t      ch0_route,
    output logic                            buf_second_half,
    output logic                            use_second_set,
    output logic                            conv_enable
);
    import asis_pkg::*;

    typedef struct packed {
        asis_axil_rsp_t    rsp;
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              alternate_mux_sampling;
        logic              split;
        logic              en;
        logic [SEL_W-1:0]  sel_a;
        logic [SEL_W-1:0]  sel_b;
        logic [AMP_W-1:0]  amp;
        logic              half;
        logic              set_b;
    } asis_state_t;

    asis_state_t       st_r;
    asis_state_t       st_nxt;
    logic              aw_go;
    logic              w_go;
    logic              ar_go;
    asis_reg_t         wr_reg;
    asis_reg_t         rd_reg;
    logic [31:0]       rd_word;
    logic [SEL_W-1:0]  active_code;
    asis_route_t       route;

    function automatic asis_reg_t reg_decode(input logic [ADDR_W-1:0] addr);
        asis_reg_t r;
        unique case (addr)
            OFF_CTRL:  r = REG_CTRL;
            OFF_SEL_A: r = REG_SEL_A;
            OFF_SEL_B: r = REG_SEL_B;
            OFF_AMP:   r = REG_AMP;
            OFF_STAT:  r = REG_STAT;
            default:   r = REG_NONE;
        endcase
        return r;
    endfunction : reg_decode

    assign aw_go  = axil_req.awvalid && st_r.rsp.awready;
    assign w_go   = axil_req.wvalid && st_r.rsp.wready;
    assign ar_go  = axil_req.arvalid && st_r.rsp.arready;
    assign wr_reg = reg_decode(st_r.waddr);
    assign rd_reg = reg_decode(axil_req.araddr);

    // [RULE3] [RULE4] set picks select
    assign active_code = st_r.set_b ? st_r.sel_b : st_r.sel_a;

    asis_route_dec u_route_dec (
        .clk      (clk),
        .rst      (rst),
        .code     (active_code),
        .amp_mode (st_r.amp),
        .route    (route)
    );

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (rd_reg)
            REG_CTRL: begin
                rd_word[CTRL_ALTERNATE_MUX_SAMPLING_BIT]  = st_r.alternate_mux_sampling;
                rd_word[CTRL_SPLIT_BIT] = st_r.split;
                rd_word[CTRL_EN_BIT]    = st_r.en;
            end
            REG_SEL_A: rd_word[SEL_W-1:0] = st_r.sel_a;
            REG_SEL_B: rd_word[SEL_W-1:0] = st_r.sel_b;
            REG_AMP:   rd_word[AMP_W-1:0] = st_r.amp;
            REG_STAT: begin
                rd_word[STAT_HALF_BIT]                = st_r.half;
                rd_word[STAT_SET_BIT]                 = st_r.set_b;
                rd_word[STAT_IDX_LSB+3:STAT_IDX_LSB]   = route.idx;
                rd_word[STAT_KIND_LSB+1:STAT_KIND_LSB] = route.kind;
                rd_word[STAT_RSVD_BIT]                = route.reserved;
            end
            REG_NONE: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;

        // sequencing uses the settings in force this cycle
        // [RULE11] disable rewinds both
        if (!st_r.en) begin
            st_nxt.half  = 1'b0;
            st_nxt.set_b = 1'b0;
        end else begin
            // [RULE2] no split, start
            if (!st_r.split) begin
                st_nxt.half = 1'b0;
            // [RULE1] swap on interrupt
            end else if (fill_irq) begin
                st_nxt.half = !st_r.half;
            end
            // [RULE4] only first set
            if (!st_r.alternate_mux_sampling) begin
                st_nxt.set_b = 1'b0;
            // [RULE3] alternate each sample
            end else if (sample_done) begin
                st_nxt.set_b = !st_r.set_b;
            end
        end

        // write address and data may arrive in either order
        if (aw_go) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.waddr   = axil_req.awaddr;
        end
        if (w_go) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata  = axil_req.wdata;
            st_nxt.wstrb  = axil_req.wstrb;
        end
        if (st_r.rsp.bvalid && axil_req.bready) begin
            st_nxt.rsp.bvalid = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.rsp.bvalid) begin
            st_nxt.aw_held   = 1'b0;
            st_nxt.w_held    = 1'b0;
            st_nxt.rsp.bvalid = 1'b1;
            st_nxt.rsp.bresp  = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (st_r.wstrb[0]) begin
                unique case (wr_reg)
                    REG_CTRL: begin
                        st_nxt.alternate_mux_sampling  = st_r.wdata[CTRL_ALTERNATE_MUX_SAMPLING_BIT];
                        st_nxt.split = st_r.wdata[CTRL_SPLIT_BIT];
                        st_nxt.en    = st_r.wdata[CTRL_EN_BIT];
                    end
                    REG_SEL_A: st_nxt.sel_a = st_r.wdata[SEL_W-1:0];
                    REG_SEL_B: st_nxt.sel_b = st_r.wdata[SEL_W-1:0];
                    REG_AMP:   st_nxt.amp   = st_r.wdata[AMP_W-1:0];
                    REG_STAT:  st_nxt.amp   = st_r.amp;
                    REG_NONE:  st_nxt.amp   = st_r.amp;
                endcase
            end
        end
        // ready drops while a word is parked, so nothing is overwritten
        st_nxt.rsp.awready = !st_nxt.aw_held && !st_nxt.rsp.bvalid;
        st_nxt.rsp.wready  = !st_nxt.w_held && !st_nxt.rsp.bvalid;

        if (st_r.rsp.rvalid && axil_req.rready) begin
            st_nxt.rsp.rvalid = 1'b0;
        end
        if (ar_go) begin
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata  = rd_word;
            st_nxt.rsp.rresp  = (rd_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    // all fields, control bits included, reset to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign axil_rsp        = st_r.rsp;
    assign ch0_route       = route;
    assign buf_second_half = st_r.half;
    assign use_second_set  = st_r.set_b;
    assign conv_enable     = st_r.en;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_SPLIT_SWAP: assert property ( // [RULE1]
        st_r.en && st_r.split && fill_irq |=> buf_second_half != $past(buf_second_half))
        else $error("buffer half did not swap on interrupt");
    AST_SPLIT_HOLD: assert property ( // [RULE1]
        st_r.en && st_r.split && !fill_irq |=> $stable(buf_second_half))
        else $error("buffer half moved without interrupt");
    AST_NO_SPLIT: assert property ( // [RULE2]
        !st_r.split |=> !buf_second_half)
        else $error("second half used with splitting off");
    AST_ALT_SWAP: assert property ( // [RULE3]
        st_r.en && st_r.alternate_mux_sampling && sample_done |=> use_second_set != $past(use_second_set))
        else $error("input set did not alternate");
    AST_ALT_CODE: assert property ( // [RULE3]
        st_r.en && st_r.alternate_mux_sampling && sample_done && !use_second_set
            |=> ##1 ch0_route.idx == $past(st_r.sel_b[3:0], 2) || $past(st_r.sel_b[4], 2))
        else $error("second set select not applied");
    AST_ALT_OFF: assert property ( // [RULE4]
        !st_r.alternate_mux_sampling |=> !use_second_set)
        else $error("second set used with alternation off");
    AST_DISABLE: assert property ( // [RULE11]
        !conv_enable |=> !buf_second_half && !use_second_set)
        else $error("sequence state not rewound while disabled");
    AST_BRESP: assert property (
        st_r.aw_held && st_r.w_held && !axil_rsp.bvalid |=> axil_rsp.bvalid)
        else $error("write response missing");
endmodule : asis_seq
`default_nettype wire

// [pkg/asis_pkg.sv]
`default_nettype none
package asis_pkg;
    // register byte offsets
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_SEL_A  = 8'h04;
    localparam logic [7:0]  OFF_SEL_B  = 8'h08;
    localparam logic [7:0]  OFF_AMP    = 8'h0C;
    localparam logic [7:0]  OFF_STAT   = 8'h10;
    // control field positions
    localparam int          CTRL_ALTERNATE_MUX_SAMPLING_BIT  = 0;
    localparam int          CTRL_SPLIT_BIT = 1;
    localparam int          CTRL_EN_BIT    = 2;
    // status field positions
    localparam int          STAT_HALF_BIT  = 0;
    localparam int          STAT_SET_BIT   = 1;
    localparam int          STAT_IDX_LSB   = 2;
    localparam int          STAT_KIND_LSB  = 6;
    localparam int          STAT_RSVD_BIT  = 8;
    // field widths and reset values
    localparam int          SEL_W      = 5;
    localparam int          AMP_W      = 3;
    localparam logic        CTRL_RST   = 1'b0;
    localparam logic [4:0]  SEL_RST    = 5'h00;
    localparam logic [2:0]  AMP_RST    = 3'h0;
    // channel-0 positive input codes
    localparam logic [4:0]  CODE_PIN_MAX = 5'h0F;
    localparam logic [4:0]  CODE_OPEN    = 5'h1F;
    localparam logic [4:0]  CODE_TEMP    = 5'h1E;
    localparam logic [4:0]  CODE_AMP3    = 5'h1A;
    localparam logic [4:0]  CODE_AMP2    = 5'h19;
    localparam logic [4:0]  CODE_AMP1    = 5'h18;
    // amplifier numbers and the pins they share
    localparam logic [3:0]  AMP1_IDX     = 4'h1;
    localparam logic [3:0]  AMP2_IDX     = 4'h2;
    localparam logic [3:0]  AMP3_IDX     = 4'h3;
    localparam logic [3:0]  AMP1_PIN     = 4'h3;
    localparam logic [3:0]  AMP2_PIN     = 4'h0;
    localparam logic [3:0]  AMP3_PIN     = 4'h6;
    // bus responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {RK_PIN, RK_AMP, RK_TEMP, RK_OPEN} asis_route_kind_t;

    typedef struct packed {
        asis_route_kind_t kind;
        logic [3:0]       idx;
        logic             reserved;
    } asis_route_t;

    typedef enum logic [2:0] {REG_CTRL, REG_SEL_A, REG_SEL_B, REG_AMP, REG_STAT,
                              REG_NONE} asis_reg_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } asis_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } asis_axil_rsp_t;
endpackage : asis_pkg
`default_nettype wire

// [core/asis_route_dec.sv]
`default_nettype none
module asis_route_dec (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [4:0]              code,
    input  wire logic [2:0]              amp_mode,
    output var  asis_pkg::asis_route_t   route
);
    import asis_pkg::*;

    asis_route_t route_r;
    asis_route_t route_nxt;

    function automatic asis_route_t amp_or_pin(input logic sel, input logic [3:0] amp,
                                               input logic [3:0] pin);
        asis_route_t r;
        r.reserved = 1'b0;
        r.kind     = sel ? RK_AMP : RK_PIN;
        r.idx      = sel ? amp : pin;
        return r;
    endfunction : amp_or_pin

    always_comb begin
        route_nxt = '{kind: RK_OPEN, idx: 4'h0, reserved: 1'b0};
        // [RULE5] direct pin codes
        if (code <= CODE_PIN_MAX) begin
            route_nxt.kind = RK_PIN;
            route_nxt.idx  = code[3:0];
        end else begin
            unique case (code)
                // [RULE6] open input
                CODE_OPEN: route_nxt.kind = RK_OPEN;
                // [RULE7] temperature diode
                CODE_TEMP: route_nxt.kind = RK_TEMP;
                // [RULE8] [RULE10] amp or pin
                CODE_AMP3: route_nxt = amp_or_pin(amp_mode[2], AMP3_IDX, AMP3_PIN);
                CODE_AMP2: route_nxt = amp_or_pin(amp_mode[1], AMP2_IDX, AMP2_PIN);
                CODE_AMP1: route_nxt = amp_or_pin(amp_mode[0], AMP1_IDX, AMP1_PIN);
                // [RULE9] reserved left open
                default: route_nxt.reserved = 1'b1;
            endcase
        end
    end

    // reserved codes leave the input open rather than guess a connection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            route_r <= '{kind: RK_OPEN, idx: 4'h0, reserved: 1'b0};
        end else begin
            route_r <= route_nxt;
        end
    end

    assign route = route_r;

    AST_PIN_DIRECT: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        code <= CODE_PIN_MAX |=> route.kind == RK_PIN && route.idx == $past(code[3:0]))
        else $error("pin code not routed directly");
    AST_OPEN_CODE: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        code == CODE_OPEN |=> route.kind == RK_OPEN && !route.reserved)
        else $error("open code not open");
    AST_TEMP_CODE: assert property (@(posedge clk) disable iff (rst) // [RULE7]
        code == CODE_TEMP |=> route.kind == RK_TEMP)
        else $error("temperature code not routed to diode");
    AST_AMP3_CODE: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        code == CODE_AMP3 |=> route.idx == ($past(amp_mode[2]) ? AMP3_IDX : AMP3_PIN))
        else $error("amp 3 code wrong source");
    AST_AMP_MODE: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        code == CODE_AMP1 |=> route.kind == ($past(amp_mode[0]) ? RK_AMP : RK_PIN)
                          && route.idx == ($past(amp_mode[0]) ? AMP1_IDX : AMP1_PIN))
        else $error("amp mode bit ignored");
endmodule : asis_route_dec
`default_nettype wire

// [bench/test_adc_sample_input_sequencer.sv]
`default_nettype none
module test_adc_sample_input_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import asis_pkg::*;

    typedef struct packed {
        logic [4:0]       code;
        logic [2:0]       amp;
        asis_route_kind_t kind;
        logic [3:0]       idx;
        logic             res;
    } asis_row_t;

    logic           clk         = 1'b0;
    logic           rst         = 1'b1;
    asis_axil_req_t axil_req    = '0;
    asis_axil_rsp_t axil_rsp;
    logic           sample_done = 1'b0;
    logic           fill_irq    = 1'b0;
    asis_route_t    ch0_route;
    logic           buf_second_half;
    logic           use_second_set;
    logic           conv_enable;
    int             err_count   = 0;
    int             n_checks    = 0;
    logic [31:0]    rd;
    logic [1:0]     rs;

    // op-amp codes 26 and 24 are listed with both mode settings, code 25 with its bit set only, reserved codes 27, 29, 16 and 22 sampled
    asis_row_t rows [14] = '{
        '{5'h00, 3'h0, RK_PIN, 4'h0, 1'b0}, '{5'h07, 3'h0, RK_PIN, 4'h7, 1'b0},
        '{5'h0F, 3'h0, RK_PIN, 4'hF, 1'b0}, '{5'h1F, 3'h0, RK_OPEN, 4'h0, 1'b0},
        '{5'h1E, 3'h0, RK_TEMP, 4'h0, 1'b0}, '{5'h1A, 3'h4, RK_AMP, 4'h3, 1'b0},
        '{5'h1A, 3'h3, RK_PIN, 4'h6, 1'b0}, '{5'h18, 3'h1, RK_AMP, 4'h1, 1'b0},
        '{5'h18, 3'h6, RK_PIN, 4'h3, 1'b0}, '{5'h19, 3'h2, RK_AMP, 4'h2, 1'b0},
        '{5'h1D, 3'h0, RK_OPEN, 4'h0, 1'b1}, '{5'h1B, 3'h0, RK_OPEN, 4'h0, 1'b1},
        '{5'h10, 3'h0, RK_OPEN, 4'h0, 1'b1}, '{5'h16, 3'h0, RK_OPEN, 4'h0, 1'b1}};

    always #4 clk = ~clk;

    asis_seq i_dut (
        .clk             (clk),
        .rst             (rst),
        .axil_req        (axil_req),
        .axil_rsp        (axil_rsp),
        .sample_done     (sample_done),
        .fill_irq        (fill_irq),
        .ch0_route       (ch0_route),
        .buf_second_half (buf_second_half),
        .use_second_set  (use_second_set),
        .conv_enable     (conv_enable)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // handshakes are judged mid-cycle, so the edge that takes them is known ahead
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, b;
        @(posedge clk);
        axil_req.awvalid <= 1'b1;
        axil_req.awaddr  <= a;
        axil_req.wvalid  <= 1'b1;
        axil_req.wdata   <= d;
        axil_req.wstrb   <= 4'hF;
        axil_req.bready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            aw = axil_req.awvalid && axil_rsp.awready;
            w  = axil_req.wvalid && axil_rsp.wready;
            b  = axil_req.bready && axil_rsp.bvalid;
            rs = axil_rsp.bresp;
            @(posedge clk);
            if (aw) axil_req.awvalid <= 1'b0;
            if (w) axil_req.wvalid <= 1'b0;
            if (b) begin
                axil_req.bready <= 1'b0;
                return;
            end
        end
        err_count++;
        $display("BAD write answer expected bvalid seen none");
    endtask : axw

    task automatic axr(input logic [7:0] a);
        bit ar, r;
        @(posedge clk);
        axil_req.arvalid <= 1'b1;
        axil_req.araddr  <= a;
        axil_req.rready  <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            ar = axil_req.arvalid && axil_rsp.arready;
            r  = axil_req.rready && axil_rsp.rvalid;
            rd = axil_rsp.rdata;
            rs = axil_rsp.rresp;
            @(posedge clk);
            if (ar) axil_req.arvalid <= 1'b0;
            if (r) begin
                axil_req.rready <= 1'b0;
                return;
            end
        end
        err_count++;
        $display("BAD read answer expected rvalid seen none");
    endtask : axr

    // pulse held for cyc edges, then one more edge lets the route follow
    task automatic pulse(input bit irq, input int cyc);
        @(posedge clk);
        if (irq) fill_irq <= 1'b1;
        else sample_done <= 1'b1;
        repeat (cyc) @(posedge clk);
        fill_irq    <= 1'b0;
        sample_done <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask : pulse

    task automatic seq_chk(input logic half, input logic set, input logic [3:0] idx);
        chk("half", {31'h0, half}, {31'h0, buf_second_half});
        chk("set", {31'h0, set}, {31'h0, use_second_set});
        chk("route idx", {28'h0, idx}, {28'h0, ch0_route.idx});
    endtask : seq_chk

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        seq_chk(1'b0, 1'b0, 4'h0);
        axr(OFF_CTRL);
        chk("ctrl reset", 32'h0, rd);
        axw(OFF_CTRL, 32'h4);
        @(negedge clk);
        chk("enable", 32'h1, {31'h0, conv_enable});
        foreach (rows[i]) begin
            axw(OFF_AMP, {29'h0, rows[i].amp});
            axw(OFF_SEL_A, {27'h0, rows[i].code});
            @(negedge clk);
            chk("kind", {30'h0, rows[i].kind}, {30'h0, ch0_route.kind});
            chk("res", {31'h0, rows[i].res}, {31'h0, ch0_route.reserved});
            if (rows[i].kind == RK_PIN || rows[i].kind == RK_AMP)
                chk("idx", {28'h0, rows[i].idx}, {28'h0, ch0_route.idx});
            axr(OFF_STAT);
            chk("status", {23'h0, rows[i].res, rows[i].kind}, {23'h0, rd[8:6]});
        end
        axr(8'h14);
        chk("bad read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("bad read data", 32'h0, rd);
        axw(8'h14, 32'hFFFF_FFFF);
        chk("bad write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axw(OFF_AMP, 32'h0);
        axw(OFF_SEL_A, 32'h5);
        axw(OFF_SEL_B, 32'h9);
        axw(OFF_CTRL, 32'h7);
        pulse(1'b0, 1);
        seq_chk(1'b0, 1'b1, 4'h9);
        pulse(1'b0, 1);
        seq_chk(1'b0, 1'b0, 4'h5);
        pulse(1'b0, 2);
        seq_chk(1'b0, 1'b0, 4'h5);
        pulse(1'b1, 1);
        seq_chk(1'b1, 1'b0, 4'h5);
        pulse(1'b1, 1);
        seq_chk(1'b0, 1'b0, 4'h5);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        seq_chk(1'b1, 1'b1, 4'h9);
        axw(OFF_CTRL, 32'h3);
        // the rewound set reaches the route one edge later
        @(posedge clk);
        @(negedge clk);
        seq_chk(1'b0, 1'b0, 4'h5);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        seq_chk(1'b0, 1'b0, 4'h5);
        axw(OFF_CTRL, 32'h4);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        seq_chk(1'b0, 1'b0, 4'h5);
        axw(OFF_CTRL, 32'h7);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        seq_chk(1'b0, 1'b0, 4'h0);
        chk("enable in reset", 32'h0, {31'h0, conv_enable});
        @(posedge clk);
        rst <= 1'b0;
        axr(OFF_CTRL);
        chk("ctrl after reset", 32'h0, rd);
        stop_test;
    end

    // whole run is a few hundred cycles; this bound is generous
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("BAD watchdog expected finish seen timeout");
        stop_test;
    end
endmodule : test_adc_sample_input_sequencer
`default_nettype wire
